// ===== core/wwdc_pkg.sv
// Shared constants for the window watchdog configuration block
package wwdc_pkg;
  // ----------------------------------------
  // Register offsets and reset values
  // ----------------------------------------
  localparam logic [7:0] OFS_TIMING = 8'h1c;
  localparam logic [7:0] OFS_OUTCFG = 8'h1d;
  localparam logic [7:0] OFS_STATUS = 8'h1e;
  localparam logic [7:0] RST_TIMING = 8'h00;
  localparam logic [7:0] RST_OUTCFG = 8'h01;
  localparam logic [7:0] RST_STATUS = 8'h00;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CLOSED_LSB = 6;
  localparam int OPEN_LSB = 4;
  localparam int FIRST_LSB = 2;
  localparam int THRESH_LSB = 0;
  localparam int LOCK_BIT = 7;
  localparam int BLOCKING_BIT = 4;
  localparam int RELOAD_BIT = 3;
  localparam int PULLDOWN_BIT = 2;
  localparam int POLARITY_BIT = 1;
  localparam int DRIVE_BIT = 0;
  localparam int FLAG_CLR_BIT = 4;
  localparam int FLAG_BIT = 3;
  localparam int CNT_CLR_BIT = 2;
  localparam int CNT_LSB = 0;
  localparam int RSV_STATUS_LSB = 5;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam logic [12:0] RESET_PULSE_MS = 13'h0001;
  localparam int MS_W = 13;

  typedef enum logic [1:0] {WINDOW_CLOSED, WINDOW_OPEN, WINDOW_FIRST} wwdc_window_t;

  // Window length in milliseconds for a kind of window and its 2-bit code
  function automatic logic [12:0] window_ms(input wwdc_window_t kind, input logic [1:0] code);
    logic [12:0] ms;
    ms = 13'h0000;
    case (kind)
      WINDOW_CLOSED: begin
        case (code)
          2'h0: ms = 13'd10;
          2'h1: ms = 13'd20;
          2'h2: ms = 13'd50;
          default: ms = 13'd100;
        endcase
      end
      WINDOW_OPEN: begin
        case (code)
          2'h0: ms = 13'd20;
          2'h1: ms = 13'd100;
          2'h2: ms = 13'd200;
          default: ms = 13'd600;
        endcase
      end
      default: begin
        case (code)
          2'h0: ms = 13'd200;
          2'h1: ms = 13'd600;
          2'h2: ms = 13'd2000;
          default: ms = 13'd5000;
        endcase
      end
    endcase
    return ms;
  endfunction

  // Pulse count that starts a restart; zero means restart disabled
  function automatic logic [2:0] threshold_pulses(input logic [1:0] code);
    logic [2:0] n;
    case (code)
      2'h1: n = 3'h1;
      2'h2: n = 3'h2;
      2'h3: n = 3'h4;
      default: n = 3'h0;
    endcase
    return n;
  endfunction
endpackage

// ===== core/wwdc_pin_sync.sv
// Three-stage pin synchroniser with agreement filter and rising edge pulse
`timescale 1ns/1ns
module wwdc_pin_sync (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  // Pin and filtered result
  input wire logic i_pin,
  output logic o_level,
  output logic o_rise
);
  logic [2:0] sync_reg;
  logic [2:0] sync_next;
  logic level_reg;
  logic level_next;
  logic rise_reg;
  logic rise_next;

  // First stage feeds only the second; a change counts when stages two and three agree
  always_comb begin
    sync_next = {sync_reg[1:0], i_pin};
    level_next = level_reg;
    rise_next = 1'b0;
    if (sync_reg[1] == sync_reg[2]) begin
      level_next = sync_reg[2];
      rise_next = sync_reg[2] & ~level_reg;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync_reg <= 3'h0;
      level_reg <= 1'b0;
      rise_reg <= 1'b0;
    end else if (i_clk_en) begin
      sync_reg <= sync_next;
      level_reg <= level_next;
      rise_reg <= rise_next;
    end
  end

  assign o_level = level_reg;
  assign o_rise = rise_reg;
endmodule

// ===== core/wwdc_timer.sv
// Millisecond down-counter with a cycle prescaler
`timescale 1ns/1ns
module wwdc_timer #(
  parameter int MS_CYCLES = 250000
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  // Control
  input wire logic i_load,
  input wire logic [12:0] i_load_ms,
  output logic o_done
);
  localparam int PW = $clog2(MS_CYCLES + 1);
  localparam logic [PW-1:0] PRE_LAST = PW'(MS_CYCLES - 1);

  logic [PW-1:0] pre_reg;
  logic [PW-1:0] pre_next;
  logic [12:0] ms_reg;
  logic [12:0] ms_next;
  logic done_reg;
  logic done_next;

  // Load restarts both stages so every window is timed from its own start
  always_comb begin
    pre_next = pre_reg;
    ms_next = ms_reg;
    done_next = 1'b0;
    if (i_load) begin
      pre_next = PRE_LAST;
      ms_next = i_load_ms;
    end else if (ms_reg != 13'h0000) begin
      if (pre_reg == '0) begin
        pre_next = PRE_LAST;
        ms_next = ms_reg - 13'h0001;
        done_next = (ms_reg == 13'h0001);
      end else begin
        pre_next = pre_reg - PW'(1);
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pre_reg <= '0;
      ms_reg <= 13'h0000;
      done_reg <= 1'b0;
    end else if (i_clk_en) begin
      pre_reg <= pre_next;
      ms_reg <= ms_next;
      done_reg <= done_next;
    end
  end

  assign o_done = done_reg;
endmodule

// ===== core/wwdc_top.sv
// Window watchdog configuration, lock, status and reset output
`timescale 1ns/1ns
module wwdc_top #(
  parameter int MS_CYCLES = wwdc_pkg::MS_CYCLES
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  // Register port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // Programmed defaults
  input wire logic [7:0] i_otp_timing,
  input wire logic [4:0] i_otp_outcfg,
  // Trigger pin
  input wire logic i_trigger_in_pin,
  output logic o_trigger_pin_pulldown,
  // Reset output pin
  output logic o_reset_out_pin,
  output logic o_reset_out_pin_oe,
  // System restart
  output logic o_sys_restart,
  output logic o_otp_reload
);
  typedef enum logic [1:0] {ST_FIRST, ST_CLOSED, ST_OPEN, ST_PULSE} wwdc_state_t;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] timing_reg;
  logic [7:0] timing_next;
  logic [6:0] outcfg_reg;
  logic [6:0] outcfg_next;
  logic config_lock_reg;
  logic config_lock_next;
  logic [2:0] status_rsv_reg;
  logic [2:0] status_rsv_next;
  logic restart_occurred_flag_reg;
  logic restart_occurred_flag_next;
  logic [1:0] restart_count_value_reg;
  logic [1:0] restart_count_value_next;
  logic otp_boot_reg;
  logic otp_boot_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  wwdc_state_t state_reg;
  wwdc_state_t state_next;
  logic restart_reg;
  logic restart_next;
  logic reload_reg;
  logic reload_next;

  logic trig_rise;
  logic timer_load;
  logic [12:0] timer_ms;
  logic timer_done;
  logic fault;
  logic wr_timing;
  logic wr_outcfg;
  logic wr_status;
  logic flag_clear;
  logic count_clear;
  logic [2:0] pulses_after;
  logic [2:0] thresh;
  logic restart_go;
  logic reset_active;

  // ----------------------------------------
  // Trigger synchroniser and window timer
  // ----------------------------------------
  wwdc_pin_sync u_trig (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_pin(i_trigger_in_pin),
    .o_level(),
    .o_rise(trig_rise)
  );

  wwdc_timer #(
    .MS_CYCLES(MS_CYCLES)
  ) u_timer (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_clk_en(i_clk_en),
    .i_load(timer_load),
    .i_load_ms(timer_ms),
    .o_done(timer_done)
  );

  // ----------------------------------------
  // Window sequencer
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    timer_load = 1'b0;
    timer_ms = 13'h0000;
    fault = 1'b0;
    case (state_reg)
      ST_FIRST: begin
        if (trig_rise) begin
          state_next = ST_CLOSED;
          timer_load = 1'b1;
          timer_ms = wwdc_pkg::window_ms(wwdc_pkg::WINDOW_CLOSED,
                                         timing_reg[wwdc_pkg::CLOSED_LSB +: 2]);
        end else if (timer_done) begin
          fault = 1'b1;
        end
      end
      ST_CLOSED: begin
        // Servicing too early is as much a fault as not servicing at all
        if (trig_rise) begin
          fault = 1'b1;
        end else if (timer_done) begin
          state_next = ST_OPEN;
          timer_load = 1'b1;
          timer_ms = wwdc_pkg::window_ms(wwdc_pkg::WINDOW_OPEN,
                                         timing_reg[wwdc_pkg::OPEN_LSB +: 2]);
        end
      end
      ST_OPEN: begin
        if (trig_rise) begin
          state_next = ST_CLOSED;
          timer_load = 1'b1;
          timer_ms = wwdc_pkg::window_ms(wwdc_pkg::WINDOW_CLOSED,
                                         timing_reg[wwdc_pkg::CLOSED_LSB +: 2]);
        end else if (timer_done) begin
          fault = 1'b1;
        end
      end
      ST_PULSE: begin
        if (timer_done) begin
          state_next = ST_FIRST;
          timer_load = 1'b1;
          timer_ms = wwdc_pkg::window_ms(wwdc_pkg::WINDOW_FIRST,
                                         timing_reg[wwdc_pkg::FIRST_LSB +: 2]);
        end
      end
      default: begin
        state_next = ST_FIRST;
      end
    endcase
    // Leaving reset, the first window is the long one
    if (otp_boot_reg) begin
      state_next = ST_FIRST;
      timer_load = 1'b1;
      timer_ms = wwdc_pkg::window_ms(wwdc_pkg::WINDOW_FIRST,
                                     i_otp_timing[wwdc_pkg::FIRST_LSB +: 2]);
    end else if (fault) begin
      state_next = ST_PULSE;
      timer_load = 1'b1;
      timer_ms = wwdc_pkg::RESET_PULSE_MS;
    end
  end

  // ----------------------------------------
  // Register decode and restart counting
  // ----------------------------------------
  assign wr_timing = i_reg_wr && (i_reg_addr == wwdc_pkg::OFS_TIMING);
  assign wr_outcfg = i_reg_wr && (i_reg_addr == wwdc_pkg::OFS_OUTCFG);
  assign wr_status = i_reg_wr && (i_reg_addr == wwdc_pkg::OFS_STATUS);
  assign flag_clear = wr_status && i_reg_wdata[wwdc_pkg::FLAG_CLR_BIT];
  assign count_clear = wr_status && i_reg_wdata[wwdc_pkg::CNT_CLR_BIT];
  assign thresh = wwdc_pkg::threshold_pulses(timing_reg[wwdc_pkg::THRESH_LSB +: 2]);
  assign pulses_after = {1'b0, (count_clear ? 2'h0 : restart_count_value_reg)} + 3'h1;
  // Equality, not reaching-or-above: a blocked count must wrap round before it restarts
  // A set flag in blocking mode holds off the next restart
  assign restart_go = fault && (thresh != 3'h0) && (pulses_after == thresh) &&
                      !(outcfg_reg[wwdc_pkg::BLOCKING_BIT] && restart_occurred_flag_reg);

  // ----------------------------------------
  // Register next values
  // ----------------------------------------
  always_comb begin
    timing_next = timing_reg;
    outcfg_next = outcfg_reg;
    config_lock_next = config_lock_reg;
    status_rsv_next = status_rsv_reg;
    restart_occurred_flag_next = restart_occurred_flag_reg;
    restart_count_value_next = restart_count_value_reg;
    otp_boot_next = 1'b0;
    restart_next = restart_go;
    reload_next = restart_go && outcfg_reg[wwdc_pkg::RELOAD_BIT];
    if (otp_boot_reg) begin
      timing_next = i_otp_timing;
      outcfg_next = {2'b00, i_otp_outcfg};
    end else if (restart_go && outcfg_reg[wwdc_pkg::RELOAD_BIT]) begin
      // A reload is a restart, not a write, so it goes through a lock too
      timing_next = i_otp_timing;
      outcfg_next = {outcfg_reg[6:5], i_otp_outcfg};
    end else if (!config_lock_reg) begin
      // Locked timing and outcfg writes fall through here and change nothing
      if (wr_timing) begin
        timing_next = i_reg_wdata;
      end
      if (wr_outcfg) begin
        outcfg_next = i_reg_wdata[6:0];
        config_lock_next = i_reg_wdata[wwdc_pkg::LOCK_BIT];
      end
    end
    if (wr_status) begin
      status_rsv_next = i_reg_wdata[wwdc_pkg::RSV_STATUS_LSB +: 3];
    end
    if (count_clear) begin
      restart_count_value_next = 2'h0;
    end
    if (fault) begin
      // A clear arriving in the same cycle applies first, then the pulse counts from zero
      restart_count_value_next = restart_go ? 2'h0 : pulses_after[1:0];
    end
    // Setting wins over a clear arriving in the same cycle
    restart_occurred_flag_next = restart_go ||
                                 (restart_occurred_flag_reg && !flag_clear);
    // Read data comes from a flop so the bus never sees decode glitches
    rdata_next = rdata_reg;
    if (i_reg_rd) begin
      case (i_reg_addr)
        wwdc_pkg::OFS_TIMING: rdata_next = timing_reg;
        wwdc_pkg::OFS_OUTCFG: rdata_next = {config_lock_reg, outcfg_reg};
        // Clear bits complete in one cycle, so they always read zero; the count is
        // meaningful for threshold codes 1 to 3 only, since code 0 wraps past it
        wwdc_pkg::OFS_STATUS: rdata_next = {status_rsv_reg, 1'b0, restart_occurred_flag_reg,
                                            1'b0, restart_count_value_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      timing_reg <= wwdc_pkg::RST_TIMING;
      outcfg_reg <= wwdc_pkg::RST_OUTCFG[6:0];
      config_lock_reg <= wwdc_pkg::RST_OUTCFG[wwdc_pkg::LOCK_BIT];
      status_rsv_reg <= wwdc_pkg::RST_STATUS[wwdc_pkg::RSV_STATUS_LSB +: 3];
      restart_occurred_flag_reg <= wwdc_pkg::RST_STATUS[wwdc_pkg::FLAG_BIT];
      restart_count_value_reg <= wwdc_pkg::RST_STATUS[wwdc_pkg::CNT_LSB +: 2];
      otp_boot_reg <= 1'b1;
      rdata_reg <= 8'h00;
      state_reg <= ST_FIRST;
      restart_reg <= 1'b0;
      reload_reg <= 1'b0;
    end else if (i_clk_en) begin
      timing_reg <= timing_next;
      outcfg_reg <= outcfg_next;
      config_lock_reg <= config_lock_next;
      status_rsv_reg <= status_rsv_next;
      restart_occurred_flag_reg <= restart_occurred_flag_next;
      restart_count_value_reg <= restart_count_value_next;
      otp_boot_reg <= otp_boot_next;
      rdata_reg <= rdata_next;
      state_reg <= state_next;
      restart_reg <= restart_next;
      reload_reg <= reload_next;
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  assign reset_active = (state_reg == ST_PULSE);
  // Open-drain only ever pulls low, so the pin level follows the enable
  always_comb begin
    if (outcfg_reg[wwdc_pkg::DRIVE_BIT]) begin
      o_reset_out_pin = 1'b0;
      o_reset_out_pin_oe = ~(reset_active ^ outcfg_reg[wwdc_pkg::POLARITY_BIT]);
    end else begin
      // Push-pull drives both levels at the analog supply level
      o_reset_out_pin = reset_active ^ outcfg_reg[wwdc_pkg::POLARITY_BIT];
      o_reset_out_pin_oe = 1'b1;
    end
  end

  assign o_trigger_pin_pulldown = outcfg_reg[wwdc_pkg::PULLDOWN_BIT];
  assign o_reg_rdata = rdata_reg;
  assign o_sys_restart = restart_reg;
  assign o_otp_reload = reload_reg;
endmodule

// ===== sim/wwdc_props.sv
// Port checks for the window watchdog configuration block
`timescale 1ns/1ns
module wwdc_props #(
  parameter int MS_CYCLES = 4
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  // Register port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  // Pins and restart
  input wire logic [7:0] i_otp_timing,
  input wire logic [4:0] i_otp_outcfg,
  input wire logic i_trigger_in_pin,
  input wire logic o_trigger_pin_pulldown,
  input wire logic o_reset_out_pin,
  input wire logic o_reset_out_pin_oe,
  input wire logic o_sys_restart,
  input wire logic o_otp_reload
);
  // ----
  // Lock shadow
  // ----
  logic lock_seen_reg;
  logic lock_seen_next;
  logic cfg_wr;
  logic cfg_rd;
  logic st_rd;
  assign cfg_wr = i_clk_en && i_reg_wr && (i_reg_addr == wwdc_pkg::OFS_OUTCFG);
  assign cfg_rd = i_clk_en && i_reg_rd && (i_reg_addr == wwdc_pkg::OFS_OUTCFG);
  assign st_rd = i_clk_en && i_reg_rd && (i_reg_addr == wwdc_pkg::OFS_STATUS);
  // Lock only ever rises, so any lock write marks it until reset
  always_comb begin
    lock_seen_next = lock_seen_reg | (cfg_wr & i_reg_wdata[wwdc_pkg::LOCK_BIT]);
  end
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lock_seen_reg <= 1'b0;
    end else begin
      lock_seen_reg <= lock_seen_next;
    end
  end
  default clocking dc @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);
  // ----
  // Assertions
  // ----
  reload_pair_a: assert property (o_otp_reload |-> o_sys_restart)
    else $error("reload without restart");
  restart_single_a: assert property (o_sys_restart |=> !o_sys_restart)
    else $error("restart pulse too long");
  pulse_start_a: assert property (o_sys_restart |-> $changed({o_reset_out_pin, o_reset_out_pin_oe}))
    else $error("reset output did not go active");
  pulse_end_a: assert property (o_sys_restart |-> ##[2:8] $changed({o_reset_out_pin, o_reset_out_pin_oe}))
    else $error("reset pulse did not end");
  pulldown_write_a: assert property ((cfg_wr && !lock_seen_reg && !o_sys_restart) |=>
    o_otp_reload || (o_trigger_pin_pulldown == $past(i_reg_wdata[wwdc_pkg::PULLDOWN_BIT])))
    else $error("pull-down bit not applied");
  pulldown_locked_a: assert property ((cfg_wr && lock_seen_reg && !o_sys_restart) |=>
    o_otp_reload || $stable(o_trigger_pin_pulldown))
    else $error("locked write changed pull-down");
  lock_sticky_a: assert property ((cfg_rd && lock_seen_reg) |=> o_reg_rdata[7])
    else $error("lock read back zero");
  status_clear_bits_a: assert property (st_rd |=> !o_reg_rdata[4] && !o_reg_rdata[2])
    else $error("clear bit read back one");
  pulldown_hold_a: assert property ((!$past(i_sys_rst) && !cfg_wr && !o_sys_restart
    && !$past(o_sys_restart)) |=> o_otp_reload || $stable(o_trigger_pin_pulldown))
    else $error("pull-down changed without write");
endmodule
bind wwdc_top wwdc_props #(.MS_CYCLES(MS_CYCLES)) u_wwdc_props (
  .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
  .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_otp_timing(i_otp_timing),
  .i_otp_outcfg(i_otp_outcfg), .i_trigger_in_pin(i_trigger_in_pin),
  .o_trigger_pin_pulldown(o_trigger_pin_pulldown), .o_reset_out_pin(o_reset_out_pin),
  .o_reset_out_pin_oe(o_reset_out_pin_oe), .o_sys_restart(o_sys_restart),
  .o_otp_reload(o_otp_reload));

// ===== sim/wwdc_host_model.sv
// Host processor model: services the trigger pin, watches the reset wire
`timescale 1ns/1ns
module wwdc_host_model (
  // Clock
  input wire logic i_sys_clk,
  // Service control
  input wire logic i_service_en,
  input wire logic [7:0] i_period,
  // Watchdog pins
  input wire logic i_reset_out_pin,
  input wire logic i_reset_out_pin_oe,
  output logic o_trigger = 1'b0,
  output logic o_reset_wire
);
  // ----
  // Trigger and wire
  // ----
  logic [7:0] cnt_reg = 8'h00;
  logic [7:0] cnt_next;
  logic trig_next;
  // Board pull-up: a released open-drain wire reads high
  assign o_reset_wire = i_reset_out_pin_oe ? i_reset_out_pin : 1'b1;
  // One rising edge per period; line stays low while not servicing
  always_comb begin
    cnt_next = 8'h00;
    trig_next = 1'b0;
    if (i_service_en) begin
      cnt_next = (cnt_reg + 8'h01 >= i_period) ? 8'h00 : cnt_reg + 8'h01;
      trig_next = cnt_next >= (i_period >> 1);
    end
  end
  always_ff @(posedge i_sys_clk) begin
    cnt_reg <= cnt_next;
    o_trigger <= trig_next;
  end
endmodule

// ===== sim/wwdc_top_test.sv
// Self-checking bench for the window watchdog configuration block
`timescale 1ns/1ns
module wwdc_top_test;
  // ----
  // Stimulus and state
  // ----
  localparam int MSC = 4;
  logic i_sys_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [7:0] i_reg_addr = 8'h00;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic [7:0] o_reg_rdata;
  logic trig;
  logic pd;
  logic rpin;
  logic roe;
  logic rwire;
  logic o_sys_restart;
  logic o_otp_reload;
  logic svc_en = 1'b0;
  logic [7:0] svc_period = 8'h50;
  int n_mismatch = 0;
  int cmp_count = 0;
  bit found;
  int gap;
  logic rl;
  int first_ms[4] = '{200, 600, 2000, 5000};
  logic [7:0] svc_tim[3] = '{8'h01, 8'h01, 8'hc1};
  logic [7:0] svc_per[3] = '{8'h50, 8'h1e, 8'h50};
  initial begin
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  wwdc_top #(.MS_CYCLES(MSC)) u_wwdc_top (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .i_clk_en(1'b1), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_otp_timing(8'h01),
    .i_otp_outcfg(5'h01), .i_trigger_in_pin(trig), .o_trigger_pin_pulldown(pd),
    .o_reset_out_pin(rpin), .o_reset_out_pin_oe(roe), .o_sys_restart(o_sys_restart),
    .o_otp_reload(o_otp_reload));
  wwdc_host_model u_wwdc_host_model (.i_sys_clk(i_sys_clk), .i_service_en(svc_en),
    .i_period(svc_period), .i_reset_out_pin(rpin), .i_reset_out_pin_oe(roe),
    .o_trigger(trig), .o_reset_wire(rwire));
  // ----
  // Tasks
  // ----
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_near(input int got, input int exp, input string what);
    cmp_count++;
    if (got < exp - 4 || got > exp + 4) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %0d want %0d", $time, what, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge i_sys_clk);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_reg_rd <= 1'b0;
    @(posedge i_sys_clk);
    chk8(o_reg_rdata, exp, what);
  endtask
  // Bounded wait for a restart pulse; n ends one above the cycles waited
  task automatic wait_rst(input int limit, output bit hit, output int n, output logic r);
    hit = 0;
    r = 1'b0;
    for (n = 1; n <= limit && !hit; n++) begin
      @(posedge i_sys_clk);
      #1;
      if (o_sys_restart === 1'b1) begin
        hit = 1;
        r = o_otp_reload;
      end
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ----
  // Tests
  // ----
  initial begin
    repeat (100000) @(posedge i_sys_clk);
    n_mismatch++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    wrap_up();
  end
  initial begin
    repeat (4) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    rd_chk(8'h1c, 8'h01, "timing default");
    rd_chk(8'h1d, 8'h01, "outcfg default");
    rd_chk(8'h1e, 8'h00, "status default");
    rd_chk(8'h1f, 8'h00, "unmapped read");
    $display("test defaults done");
    for (int i = 0; i < 8; i++) begin
      wr_reg(8'h1d, 8'(i));
      @(posedge i_sys_clk);
      #1;
      chk8({pd, rpin, roe}, {i[2], i[0] ? 1'b0 : i[1], i[0] ? !i[1] : 1'b1}, "pins");
      chk8({7'h00, rwire}, {7'h00, i[1]}, "idle wire");
    end
    $display("test pin modes done");
    wr_reg(8'h1d, 8'h00);
    wait_rst(1000, found, gap, rl);
    chk8(8'(found), 8'h01, "restart");
    chk8({7'h00, rwire}, 8'h01, "active wire");
    rd_chk(8'h1e, 8'h08, "flag set");
    wr_reg(8'h1e, 8'h10);
    rd_chk(8'h1e, 8'h00, "flag clear");
    wr_reg(8'h1c, 8'h00);
    wr_reg(8'h1e, 8'h04);
    wait_rst(900, found, gap, rl);
    chk8(8'(found), 8'h00, "restart off");
    rd_chk(8'h1e, 8'h01, "pulse count");
    wr_reg(8'h1e, 8'h04);
    rd_chk(8'h1e, 8'h00, "count clear");
    wr_reg(8'h1c, 8'h01);
    wr_reg(8'h1d, 8'h10);
    wait_rst(1000, found, gap, rl);
    chk8(8'(found), 8'h01, "first restart");
    wait_rst(1000, found, gap, rl);
    chk8(8'(found), 8'h00, "blocked restart");
    // Clear the count too: while blocked it has counted up to the threshold, so the next pulse would pass it
    wr_reg(8'h1e, 8'h14);
    wait_rst(1000, found, gap, rl);
    chk8(8'(found), 8'h01, "unblocked restart");
    for (int r = 0; r < 2; r++) begin
      wr_reg(8'h1d, r ? 8'h08 : 8'h00);
      wr_reg(8'h1c, 8'h11);
      wait_rst(1000, found, gap, rl);
      chk8({7'h00, rl}, 8'(r), "reload pulse");
      rd_chk(8'h1c, r ? 8'h01 : 8'h11, "timing after restart");
      rd_chk(8'h1d, r ? 8'h01 : 8'h00, "outcfg after restart");
    end
    $display("test restart done");
    for (int k = 0; k < 3; k++) begin
      wait_rst(2000, found, gap, rl);
      wr_reg(8'h1c, svc_tim[k]);
      svc_period <= svc_per[k];
      svc_en <= 1'b1;
      wait_rst(1500, found, gap, rl);
      svc_en <= 1'b0;
      chk8(8'(found), 8'(k > 0), "service outcome");
    end
    $display("test service done");
    for (int c = 0; c < 4; c++) begin
      wr_reg(8'h1c, 8'(c * 4 + 1));
      wait_rst(25000, found, gap, rl);
      wait_rst(25000, found, gap, rl);
      chk_near(gap, first_ms[c] * MSC + MSC, "first window");
    end
    $display("test first window done");
    wr_reg(8'h1d, 8'h84);
    rd_chk(8'h1d, 8'h84, "lock set");
    wr_reg(8'h1d, 8'h00);
    rd_chk(8'h1d, 8'h84, "lock holds");
    chk8({7'h00, pd}, 8'h01, "pull-down kept");
    wr_reg(8'h1c, 8'hff);
    rd_chk(8'h1c, 8'h0d, "timing locked");
    wr_reg(8'h1e, 8'hf4);
    rd_chk(8'h1e, 8'he0, "status while locked");
    $display("test lock done");
    wrap_up();
  end
endmodule
